// [src/fspc_pkg.sv]
// Package for the flash self-program section control: constants, types, register map
package fspc_pkg;

	// =====================================================================
	// Flash geometry
	localparam int FSPC_ADDR_W      = 14;
	localparam int FSPC_PAGE_W      = 6;
	localparam int FSPC_FLASH_WORDS = 16384;
	localparam int FSPC_HALT_START  = 12288;
	localparam int FSPC_BOOT_SIZE0  = 4096;
	localparam int FSPC_BOOT_SIZE1  = 2048;
	localparam int FSPC_BOOT_SIZE2  = 1024;
	localparam int FSPC_BOOT_SIZE3  = 512;

	// =====================================================================
	// Register map, byte offsets
	localparam logic [11:0] FSPC_CTRL_OFS   = 12'h000;
	localparam logic [11:0] FSPC_STATUS_OFS = 12'h004;
	localparam logic [11:0] FSPC_LOCK_OFS   = 12'h008;
	localparam logic [11:0] FSPC_PAGE_OFS   = 12'h00C;

	// Field positions
	localparam int FSPC_CTRL_CLR_BUSY = 0;
	localparam int FSPC_CTRL_CLR_REF  = 1;
	localparam int FSPC_ST_BUSY       = 0;
	localparam int FSPC_ST_ACTIVE     = 1;
	localparam int FSPC_ST_STALL      = 2;
	localparam int FSPC_ST_REFUSED    = 3;
	localparam int FSPC_ST_FUSE       = 4;
	localparam int FSPC_LK_APP_NOWR   = 0;
	localparam int FSPC_LK_APP_NORD   = 1;
	localparam int FSPC_LK_BOOT_NOWR  = 2;
	localparam int FSPC_LK_BOOT_NORD  = 3;

	// Reset values and response codes
	localparam logic [3:0]  FSPC_LOCK_RST = 4'h0;
	localparam logic [1:0]  FSPC_FUSE_RST = 2'h0;
	localparam logic [31:0] FSPC_ZERO32   = 32'h0000_0000;
	localparam logic [1:0]  FSPC_RESP_OK  = 2'h0;
	localparam logic [1:0]  FSPC_RESP_ERR = 2'h2;

	// =====================================================================
	// Store instruction operations and the command carrier
	typedef enum logic [1:0] {FSPC_OP_ERASE, FSPC_OP_WRITE, FSPC_OP_LOCK, FSPC_OP_RWW_CLR} fspc_op_t;

	typedef struct packed {
		fspc_op_t                 op;
		logic [FSPC_ADDR_W-1:0]   pc;
		logic [FSPC_ADDR_W-1:0]   z;
		logic [3:0]               lock_val;
	} fspc_spm_cmd_t;

endpackage

// [src/fspc_region_decode.sv]
// Address classifier: boot part versus application part, halting versus read-while-write
`timescale 1ns/10ps
module fspc_region_decode
	import fspc_pkg::*;
#(
	parameter int FLASH_WORDS = FSPC_FLASH_WORDS,
	parameter int HALT_START  = FSPC_HALT_START,
	parameter int BOOT_SIZE0  = FSPC_BOOT_SIZE0,
	parameter int BOOT_SIZE1  = FSPC_BOOT_SIZE1,
	parameter int BOOT_SIZE2  = FSPC_BOOT_SIZE2,
	parameter int BOOT_SIZE3  = FSPC_BOOT_SIZE3
)
(
	input  wire logic [FSPC_ADDR_W-1:0] addr,
	input  wire logic [1:0]             fuses,
	output logic                        in_boot,
	output logic                        in_halt
);

	// =====================================================================
	// Boundaries, one bit wider so the top of flash compares cleanly
	localparam logic [FSPC_ADDR_W:0] HALT_B  = (FSPC_ADDR_W+1)'(HALT_START);
	localparam logic [FSPC_ADDR_W:0] BOOT_B0 = (FSPC_ADDR_W+1)'(FLASH_WORDS - BOOT_SIZE0);
	localparam logic [FSPC_ADDR_W:0] BOOT_B1 = (FSPC_ADDR_W+1)'(FLASH_WORDS - BOOT_SIZE1);
	localparam logic [FSPC_ADDR_W:0] BOOT_B2 = (FSPC_ADDR_W+1)'(FLASH_WORDS - BOOT_SIZE2);
	localparam logic [FSPC_ADDR_W:0] BOOT_B3 = (FSPC_ADDR_W+1)'(FLASH_WORDS - BOOT_SIZE3);

	logic [FSPC_ADDR_W:0] boot_start;
	logic [FSPC_ADDR_W:0] addr_x;

	// Fuse-chosen split; fixed split needs no fuse; every boot start sits at or above the halt start
	always_comb
	begin
		unique case (fuses)
			2'h0:    boot_start = BOOT_B0;
			2'h1:    boot_start = BOOT_B1;
			2'h2:    boot_start = BOOT_B2;
			default: boot_start = BOOT_B3;
		endcase
	end

	assign addr_x  = {1'b0, addr};
	assign in_boot = (addr_x >= boot_start);
	assign in_halt = (addr_x >= HALT_B);

endmodule

// [src/fspc_axil_slave.sv]
// AXI4-Lite slave front end: handshakes, write strobe and read capture
`timescale 1ns/10ps
module fspc_axil_slave
	import fspc_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             wr_en,
	output logic [11:0]      wr_addr,
	output logic [31:0]      wr_data,
	output logic [3:0]       wr_strb,
	input  wire logic        wr_err,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_err
);

	logic aw_got_r;
	logic w_got_r;

	// =====================================================================
	// Write side: address and data in either order, then one response
	assign wr_en = aw_got_r & w_got_r & ~bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			awready  <= 1'b1;
			wready   <= 1'b1;
			bvalid   <= 1'b0;
			bresp    <= FSPC_RESP_OK;
			wr_addr  <= 12'h000;
			wr_data  <= FSPC_ZERO32;
			wr_strb  <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_got_r <= 1'b1;
				awready  <= 1'b0;
				wr_addr  <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_got_r <= 1'b1;
				wready  <= 1'b0;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (wr_en)
			begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				bvalid   <= 1'b1;
				bresp    <= wr_err ? FSPC_RESP_ERR : FSPC_RESP_OK;
			end
			// Ready again only once the response is gone: one write at a time
			if (bvalid && bready)
			begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// =====================================================================
	// Read side: data captured on the address handshake
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= FSPC_ZERO32;
			rresp   <= FSPC_RESP_OK;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_data;
			rresp   <= rd_err ? FSPC_RESP_ERR : FSPC_RESP_OK;
		end
		else if (rvalid && rready)
		begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

endmodule

// [src/fspc_top.sv]
// Flash self-program section control: protection, region split, stall and busy flag
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/10ps
module fspc_top
	import fspc_pkg::*;
#(
	parameter int FLASH_WORDS = FSPC_FLASH_WORDS,
	parameter int HALT_START  = FSPC_HALT_START,
	parameter int BOOT_SIZE0  = FSPC_BOOT_SIZE0,
	parameter int BOOT_SIZE1  = FSPC_BOOT_SIZE1,
	parameter int BOOT_SIZE2  = FSPC_BOOT_SIZE2,
	parameter int BOOT_SIZE3  = FSPC_BOOT_SIZE3
)
(
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [11:0]                   awaddr,
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [31:0]                   wdata,
	input  wire logic [3:0]                    wstrb,
	input  wire logic                          wvalid,
	output logic                               wready,
	output logic [1:0]                         bresp,
	output logic                               bvalid,
	input  wire logic                          bready,
	input  wire logic [11:0]                   araddr,
	input  wire logic                          arvalid,
	output logic                               arready,
	output logic [31:0]                        rdata,
	output logic [1:0]                         rresp,
	output logic                               rvalid,
	input  wire logic                          rready,
	input  wire logic [1:0]                    boot_size_fuses,
	input  wire logic                          chip_erase,
	input  wire logic                          spm_req,
	input  wire fspc_spm_cmd_t                 spm_cmd,
	input  wire logic                          fetch_req,
	input  wire logic [FSPC_ADDR_W-1:0]        fetch_addr,
	input  wire logic                          flash_done,
	output logic                               core_stall_r,
	output logic                               fetch_invalid_r,
	output logic                               flash_start_r,
	output fspc_op_t                           flash_op_r,
	output logic [FSPC_ADDR_W-FSPC_PAGE_W-1:0] flash_page_r,
	output logic [3:0]                         lock_bits_r
);

	typedef enum logic [1:0] {FSPC_IDLE, FSPC_RUN_RWW, FSPC_RUN_HALT} fspc_state_t;

	fspc_state_t        state_r;
	logic [1:0]         fuse_s1_r;
	logic [1:0]         fuse_s2_r;
	logic [1:0]         fuse_s3_r;
	logic [1:0]         fuse_r;
	logic               busy_r;
	logic               refused_r;
	logic               pc_boot;
	logic               pc_halt;
	logic               tgt_boot;
	logic               tgt_halt;
	logic               fet_boot;
	logic               fet_halt;
	logic               prog_req;
	logic               prog_ok;
	logic               lock_req;
	logic               sw_clr_busy;
	logic               sw_clr_ref;
	logic               core_clr_busy;
	logic               wr_en;
	logic [11:0]        wr_addr;
	logic [31:0]        wr_data;
	logic [3:0]         wr_strb;
	logic               wr_err;
	logic [31:0]        rd_data;
	logic               rd_err;

	// =====================================================================
	// Bus front end
	fspc_axil_slave u_bus (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_err  (wr_err),
		.rd_data (rd_data),
		.rd_err  (rd_err)
	);

	// =====================================================================
	// Fuse pins: three stages, a change counts once stages two and three agree
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fuse_s1_r <= FSPC_FUSE_RST;
			fuse_s2_r <= FSPC_FUSE_RST;
			fuse_s3_r <= FSPC_FUSE_RST;
			fuse_r    <= FSPC_FUSE_RST;
		end
		else
		begin
			fuse_s1_r <= boot_size_fuses;
			fuse_s2_r <= fuse_s1_r;
			fuse_s3_r <= fuse_s2_r;
			if (fuse_s2_r == fuse_s3_r)
				fuse_r <= fuse_s3_r;
		end
	end

	// =====================================================================
	// Region classification of executing, target and fetch addresses
	fspc_region_decode #(.FLASH_WORDS(FLASH_WORDS), .HALT_START(HALT_START), .BOOT_SIZE0(BOOT_SIZE0),
		.BOOT_SIZE1(BOOT_SIZE1), .BOOT_SIZE2(BOOT_SIZE2), .BOOT_SIZE3(BOOT_SIZE3)) u_pc (
		.addr    (spm_cmd.pc),
		.fuses   (fuse_r),
		.in_boot (pc_boot),
		.in_halt (pc_halt)
	);

	fspc_region_decode #(.FLASH_WORDS(FLASH_WORDS), .HALT_START(HALT_START), .BOOT_SIZE0(BOOT_SIZE0),
		.BOOT_SIZE1(BOOT_SIZE1), .BOOT_SIZE2(BOOT_SIZE2), .BOOT_SIZE3(BOOT_SIZE3)) u_tgt (
		.addr    (spm_cmd.z),
		.fuses   (fuse_r),
		.in_boot (tgt_boot),
		.in_halt (tgt_halt)
	);

	fspc_region_decode #(.FLASH_WORDS(FLASH_WORDS), .HALT_START(HALT_START), .BOOT_SIZE0(BOOT_SIZE0),
		.BOOT_SIZE1(BOOT_SIZE1), .BOOT_SIZE2(BOOT_SIZE2), .BOOT_SIZE3(BOOT_SIZE3)) u_fet (
		.addr    (fetch_addr),
		.fuses   (fuse_r),
		.in_boot (fet_boot),
		.in_halt (fet_halt)
	);

	// =====================================================================
	// Store instruction qualification
	assign prog_req = spm_req && (state_r == FSPC_IDLE)
		&& ((spm_cmd.op == FSPC_OP_ERASE) || (spm_cmd.op == FSPC_OP_WRITE));
	// Only boot-part code may program, anywhere, unless that part's lock forbids
	assign prog_ok  = prog_req && pc_boot
		&& !(tgt_boot && lock_bits_r[FSPC_LK_BOOT_NOWR])
		&& !(!tgt_boot && lock_bits_r[FSPC_LK_APP_NOWR]);
	assign lock_req      = spm_req && pc_boot && (spm_cmd.op == FSPC_OP_LOCK);
	assign core_clr_busy = spm_req && pc_boot && (spm_cmd.op == FSPC_OP_RWW_CLR);

	// Software clears; the busy clear is ignored while the operation still runs, the refused clear is not
	assign sw_clr_busy = wr_en && (wr_addr == FSPC_CTRL_OFS) && wr_strb[0] && wr_data[FSPC_CTRL_CLR_BUSY];
	assign sw_clr_ref  = wr_en && (wr_addr == FSPC_CTRL_OFS) && wr_strb[0] && wr_data[FSPC_CTRL_CLR_REF];

	// =====================================================================
	// Operation sequencer; stall decided by the target page's region
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r       <= FSPC_IDLE;
			core_stall_r  <= 1'b0;
			flash_start_r <= 1'b0;
			flash_op_r    <= FSPC_OP_ERASE;
			flash_page_r  <= '0;
		end
		else
		begin
			flash_start_r <= prog_ok;
			unique case (state_r)
				FSPC_IDLE:
					if (prog_ok)
					begin
						flash_op_r   <= spm_cmd.op;
						flash_page_r <= spm_cmd.z[FSPC_ADDR_W-1:FSPC_PAGE_W];
						state_r      <= tgt_halt ? FSPC_RUN_HALT : FSPC_RUN_RWW;
						core_stall_r <= tgt_halt;
					end
				FSPC_RUN_RWW, FSPC_RUN_HALT:
					if (flash_done)
					begin
						state_r      <= FSPC_IDLE;
						core_stall_r <= 1'b0;
					end
			endcase
		end
	end

	// =====================================================================
	// Busy flag: set on a read-while-write start, set beats a same-cycle clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			busy_r <= 1'b0;
		else if (prog_ok && !tgt_halt)
			busy_r <= 1'b1;
		else if ((sw_clr_busy || core_clr_busy) && (state_r == FSPC_IDLE))
			busy_r <= 1'b0;
	end

	// Refused store requests are remembered for software
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			refused_r <= 1'b0;
		else if ((spm_req && !pc_boot) || (prog_req && !prog_ok) || (spm_req && state_r != FSPC_IDLE))
			refused_r <= 1'b1;
		else if (sw_clr_ref)
			refused_r <= 1'b0;
	end

	// =====================================================================
	// Protection bits: software sets, only chip erase or reset clears
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			lock_bits_r <= FSPC_LOCK_RST;
		else if (lock_req)
			lock_bits_r <= lock_bits_r | spm_cmd.lock_val;
		else if (wr_en && (wr_addr == FSPC_LOCK_OFS) && wr_strb[0])
			lock_bits_r <= lock_bits_r | wr_data[3:0];
		else if (chip_erase)
			lock_bits_r <= FSPC_LOCK_RST;
	end

	// =====================================================================
	// Fetches from the blocked region return garbage; flag them to the core
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			fetch_invalid_r <= 1'b0;
		else
			fetch_invalid_r <= fetch_req && !fet_halt && busy_r;
	end

	// =====================================================================
	// Register read mux and error decode
	always_comb
	begin
		rd_data = FSPC_ZERO32;
		rd_err  = 1'b0;
		unique case (araddr)
			FSPC_CTRL_OFS: rd_data = FSPC_ZERO32;
			FSPC_STATUS_OFS:
			begin
				rd_data[FSPC_ST_BUSY]                  = busy_r;
				rd_data[FSPC_ST_ACTIVE]                = (state_r != FSPC_IDLE);
				rd_data[FSPC_ST_STALL]                 = core_stall_r;
				rd_data[FSPC_ST_REFUSED]               = refused_r;
				rd_data[FSPC_ST_FUSE+1:FSPC_ST_FUSE]   = fuse_r;
			end
			FSPC_LOCK_OFS: rd_data[3:0] = lock_bits_r;
			FSPC_PAGE_OFS: rd_data[FSPC_ADDR_W-FSPC_PAGE_W-1:0] = flash_page_r;
			default:       rd_err = 1'b1;
		endcase
	end

	// Status and page are read-only; writes there and elsewhere are refused
	assign wr_err = !((wr_addr == FSPC_CTRL_OFS) || (wr_addr == FSPC_LOCK_OFS));

	// =====================================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence start_halt_s;
		prog_ok && tgt_halt;
	endsequence

	sequence start_rww_s;
		prog_ok && !tgt_halt;
	endsequence

	sequence op_done_s;
		(state_r != FSPC_IDLE) && flash_done;
	endsequence

	app_no_prog_a: assert property (prog_req && !pc_boot |=> !flash_start_r)
		else $error("programming started from application part");
	page_latch_a: assert property (prog_ok |=> flash_start_r && flash_page_r == $past(spm_cmd.z[FSPC_ADDR_W-1:FSPC_PAGE_W]))
		else $error("target page not latched at start");
	halt_stall_a: assert property (start_halt_s |=> core_stall_r throughout ((state_r == FSPC_RUN_HALT) [*1]))
		else $error("halting-region operation did not stall core");
	stall_end_a: assert property (op_done_s |=> !core_stall_r && state_r == FSPC_IDLE)
		else $error("stall not released at completion");
	rww_run_a: assert property ((state_r == FSPC_RUN_RWW) |-> !core_stall_r && busy_r)
		else $error("core stalled during read-while-write operation");
	busy_set_a: assert property (start_rww_s |=> busy_r [*2] or (busy_r ##1 1'b1))
		else $error("busy flag not set on read-while-write start");
	busy_hold_a: assert property (busy_r && !sw_clr_busy && !core_clr_busy |=> busy_r)
		else $error("busy flag dropped without a clear");
	boot_in_halt_a: assert property (pc_boot |-> pc_halt)
		else $error("boot part reaches into read-while-write region");
	lock_keep_a: assert property ((lock_bits_r != FSPC_LOCK_RST) && !chip_erase |=> (lock_bits_r & $past(lock_bits_r)) == $past(lock_bits_r))
		else $error("protection bits cleared without chip erase");
	fetch_flag_a: assert property (fetch_req && !fet_halt && busy_r |=> fetch_invalid_r)
		else $error("blocked fetch not flagged");
	locked_tgt_a: assert property (prog_req && tgt_boot && lock_bits_r[FSPC_LK_BOOT_NOWR] |=> !flash_start_r)
		else $error("write to locked boot part started");

endmodule

// [verif/fspc_core_model.sv]
// Core-side model: store requests, fetches and the flash finish pulse
`timescale 1ns/10ps
module fspc_core_model
	import fspc_pkg::*;
(
	input  wire logic     aclk,
	input  wire logic     flash_start_r,
	output logic          spm_req,
	output fspc_spm_cmd_t spm_cmd,
	output logic          fetch_req,
	output logic [13:0]   fetch_addr,
	output logic          flash_done
);
	int dly = 30;
	int cnt = 0;

	// ================================
	// Quiet at time zero
	initial
	begin
		spm_req = 0;
		spm_cmd = '0;
		fetch_req = 0;
		fetch_addr = '0;
		flash_done = 0;
	end

	// One store instruction; target scrambled after release
	task automatic store_program_memory_instr(input fspc_op_t op, input logic [13:0] pc, z, input logic [3:0] lk);
		@(posedge aclk);
		spm_req <= 1;
		spm_cmd <= '{op, pc, z, lk};
		@(posedge aclk);
		spm_req <= 0;
		spm_cmd.z <= ~z;
	endtask

	// Fetch probe; boot code normally avoids the blocked region
	task automatic fetch(input logic [13:0] a);
		@(posedge aclk);
		fetch_req <= 1;
		fetch_addr <= a;
		@(posedge aclk);
		fetch_req <= 0;
		fetch_addr <= ~a;
	endtask

	// Finish pulse dly+1 cycles after flash_start_r rises, never while idle
	always @(posedge aclk)
	begin
		flash_done <= (cnt == 1);
		if (flash_start_r)
			cnt <= dly;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
endmodule

// [verif/testbench.sv]
// Testbench: bus tasks, core model and checks for the section control
`timescale 1ns/10ps
module testbench
	import fspc_pkg::*;
;
	logic          aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic          chip_erase = 0, awready, wready, bvalid, arready, rvalid, spm_req, fetch_req, flash_done;
	logic          core_stall_r, fetch_invalid_r, flash_start_r;
	logic [11:0]   awaddr = 0, araddr = 0;
	logic [31:0]   wdata = 0, rdata;
	logic [3:0]    wstrb = 4'hf, lock_bits_r;
	logic [1:0]    bresp, rresp, boot_size_fuses = 0;
	logic [7:0]    flash_page_r;
	logic [13:0]   fetch_addr;
	fspc_spm_cmd_t spm_cmd;
	fspc_op_t      flash_op_r;
	int            num_errors = 0, checks_done = 0;
	localparam logic [13:0] BT = 14'd15000;

	always #12.5 aclk = ~aclk;

	fspc_top dut_u (.*);

	fspc_core_model core_u (.aclk(aclk), .flash_start_r(flash_start_r), .spm_req(spm_req), .spm_cmd(spm_cmd),
		.fetch_req(fetch_req), .fetch_addr(fetch_addr), .flash_done(flash_done));

	// ================================
	// Shared tasks
	task automatic chk(input logic [31:0] got, exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 0;
			if (wready)
				wvalid <= 0;
			if (bvalid)
				break;
		end
		bready <= 0;
		// No answer within the limit is a failure, not a silent pass
		if (n == 40)
		begin
			num_errors++;
			$display("BAD %0t write response timeout", $time);
		end
		chk(bresp, er);
	endtask

	task automatic axr(input logic [11:0] a, input logic [31:0] ex, input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 0;
			if (rvalid)
				break;
		end
		rready <= 0;
		if (n == 40)
		begin
			num_errors++;
			$display("BAD %0t read response timeout", $time);
		end
		chk(rdata, ex);
		chk(rresp, er);
	endtask

	task automatic sp(input fspc_op_t op, input logic [13:0] pc, z, input logic [3:0] lk, input logic s);
		core_u.store_program_memory_instr(op, pc, z, lk);
		#1;
		chk(flash_start_r, s);
	endtask

	// Bounded wait for the finish pulse, then one edge for the stall to drop
	task automatic wdone;
		int n;
		for (n = 0; n < 60 && flash_done !== 1; n++)
			@(posedge aclk);
		if (n == 60)
		begin
			num_errors++;
			$display("BAD %0t flash finish timeout", $time);
		end
		@(posedge aclk);
		#1;
	endtask

	task automatic summarize;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ================================
	// Main sequence
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		repeat (5) @(posedge aclk);
		axr(12'h004, 0, 0);
		axr(12'h008, 0, 0);
		sp(FSPC_OP_WRITE, BT, 14'h0345, 0, 1);
		chk(core_stall_r, 0);
		chk(flash_page_r, 8'h0D);
		chk(flash_op_r, FSPC_OP_WRITE);
		axr(12'h004, 3, 0);
		core_u.fetch(14'd100);
		#1;
		chk(fetch_invalid_r, 1);
		core_u.fetch(14'd13000);
		#1;
		chk(fetch_invalid_r, 0);
		sp(FSPC_OP_ERASE, BT, 14'd13000, 0, 0);
		wdone;
		axr(12'h004, 9, 0);
		axw(12'h000, 3, 0);
		axr(12'h004, 0, 0);
		core_u.fetch(14'd100);
		#1;
		chk(fetch_invalid_r, 0);
		sp(FSPC_OP_ERASE, BT, 14'd13000, 0, 1);
		chk(core_stall_r, 1);
		axr(12'h004, 6, 0);
		chk(core_stall_r, 1);
		wdone;
		chk(core_stall_r, 0);
		core_u.dly = 1;
		sp(FSPC_OP_WRITE, BT, 14'd16000, 0, 1);
		chk(core_stall_r, 1);
		wdone;
		sp(FSPC_OP_WRITE, 14'd100, 14'd13000, 0, 0);
		axr(12'h004, 8, 0);
		axw(12'h000, 2, 0);
		axw(12'h008, 1, 0);
		chk(lock_bits_r, 1);
		sp(FSPC_OP_WRITE, BT, 14'd100, 0, 0);
		sp(FSPC_OP_WRITE, BT, 14'd16000, 0, 1);
		wdone;
		axw(12'h008, 0, 0);
		axr(12'h008, 1, 0);
		@(posedge aclk);
		chip_erase <= 1;
		@(posedge aclk);
		chip_erase <= 0;
		#1;
		chk(lock_bits_r, 0);
		sp(FSPC_OP_LOCK, BT, 0, 4'h4, 0);
		chk(lock_bits_r, 4);
		sp(FSPC_OP_WRITE, BT, 14'd16000, 0, 0);
		axw(12'h004, 1, 2);
		axr(12'h010, 0, 2);
		axw(12'h000, 2, 0);
		@(posedge aclk);
		boot_size_fuses <= 3;
		repeat (5) @(posedge aclk);
		sp(FSPC_OP_WRITE, BT, 14'd100, 0, 0);
		sp(FSPC_OP_WRITE, 14'd16000, 14'd100, 0, 1);
		wdone;
		axr(12'h004, 32'h39, 0);
		sp(FSPC_OP_RWW_CLR, 14'd16000, 0, 0, 0);
		axr(12'h004, 32'h38, 0);
		summarize;
	end

	// Watchdog: the sequence needs well under a thousand cycles
	initial
	begin
		repeat (3000) @(posedge aclk);
		num_errors++;
		summarize;
	end
endmodule
